/* rtl/cht_status_regs.sv */
`timescale 1ns/100ps
module cht_status_regs import cht_pkg::*; (
    // clock and reset
    input  wire logic           clk,
    input  wire logic           reset,
    // apb slave
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [31:0]    paddr,
    input  wire logic [31:0]    pwdata,
    output logic [31:0]         prdata,
    output logic                pready,
    output logic                pslverr,
    // events and levels from the datapath
    input  wire cht_event_type  ev,
    // fifo fill in data units
    input  wire logic [5:0]     fifo_count,
    // setup seen by the datapath
    output cht_dma_type         dma_cfg,
    output cht_cfg_type         host_cfg,
    output logic                chunk_req,
    output logic [3:0]          first_keep,
    // interrupt to the system
    output logic                irq
);

    cht_state_type s;        // registered state
    cht_state_type next_s;   // next state

    // bus phase decode
    logic        setup;      // first cycle of a transfer
    logic        access;     // completing cycle
    logic        wr;         // write taking effect
    logic        rd_status;  // status read completing
    logic        hit;        // address maps to a register
    logic [31:0] rdval;      // value a read will return
    logic [31:0] set_v;      // flags raised this cycle
    logic [31:0] clr_v;      // flags dropped this cycle
    logic [31:0] read_clr;   // flags a status read drops
    logic        cfg_wr;     // accepted configuration write
    logic        xfer_idle;  // command ready and bus idle

    // transfer phases; no wait states are inserted
    always_comb begin
        setup     = psel && !penable;
        access    = psel && penable;
        wr        = access && pwrite;
        rd_status = access && !pwrite && (paddr == ADDR_HOST_STATUS);
        xfer_idle = ev.cmd_ready && ev.data_idle;
    end

    // read mux, sampled in the setup cycle so that the data
    // come from a flop and the read-clear knows what was seen
    always_comb begin
        rdval = '0;
        hit   = 1'b1;
        case (paddr)
            ADDR_HOST_STATUS: begin
                rdval = s.status;
            end
            ADDR_IRQ_MASK_VIEW: begin
                rdval = s.mask;                          // [R19]
            end
            ADDR_DMA_SETUP: begin
                rdval[DMA_OFS_LSB +: 2] = s.dma.offset;
                rdval[DMA_CHK_LSB +: 3] = s.dma.chunk;
                rdval[DMA_EN_POS]       = s.dma.enable;
                rdval[DMA_ROPT_POS]     = s.dma.read_opt;
            end
            ADDR_HOST_CFG: begin
                rdval[CFG_FIFO_POS]  = s.cfg.fifo_mode;
                rdval[CFG_FERR_POS]  = s.cfg.flow_error_reset_ctrl;
                rdval[CFG_HSPD_POS]  = s.cfg.high_speed;
                rdval[CFG_LSYNC_POS] = s.cfg.sync_last_block;
            end
            ADDR_WP_MODE: begin
                rdval[WP_EN_POS] = s.write_protect_enable;
            end
            // write-only registers read as zero
            ADDR_IRQ_ENABLE_SET,
            ADDR_IRQ_ENABLE_CLEAR: begin
                rdval = '0;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // event vector in status bit order
    always_comb begin
        set_v = '0;
        set_v[POS_COMPL_RCV]   = ev.completion_received;    // [R2]
        set_v[POS_RESP_INDEX]  = ev.resp_index_err;         // [R3]
        set_v[POS_RESP_DIR]    = ev.resp_direction_err;     // [R4]
        set_v[POS_RESP_CRC]    = ev.resp_crc_err;           // [R5]
        set_v[POS_RESP_END]    = ev.resp_endbit_err;        // [R6]
        set_v[POS_RESP_TMO]    = ev.resp_timeout_err;       // [R7]
        set_v[POS_DATA_CRC]    = ev.data_crc_err;           // [R8]
        set_v[POS_DATA_TMO]    = ev.data_timeout_err;       // [R9]
        set_v[POS_COMPL_TMO]   = ev.completion_timeout_err; // [R10]
        set_v[POS_BLK_OVR]     = ev.dma_block_overrun_err;  // [R11]
        set_v[POS_DMA_DONE]    = ev.dma_done;               // [R12]
        set_v[POS_BOOT_ACK]    = ev.boot_ack;               // [R14]
        set_v[POS_BOOT_ACK_E]  = ev.boot_ack_err;           // [R15]
        set_v[POS_RX_OVERRUN]  = ev.rx_overrun_err;         // [R16]
        set_v[POS_TX_UNDERRUN] = ev.tx_underrun_err;        // [R17]
    end

    // clear vector; a status read drops only the bits that its reader
    // saw, so an event landing after the setup cycle survives into
    // the next read
    always_comb begin
        cfg_wr   = wr && (paddr == ADDR_HOST_CFG)
                   && !s.write_protect_enable;
        read_clr = CLR_ON_READ;
        if (s.cfg.flow_error_reset_ctrl) begin
            read_clr = CLR_ON_READ | CLR_ON_FLOW;        // [R23]
        end
        clr_v = '0;
        if (rd_status) begin
            clr_v = clr_v | (s.prdata & read_clr);       // [R2] [R8]
        end
        if (ev.command_write) begin
            clr_v = clr_v | CLR_ON_CMD;                  // [R3] [R7]
        end
        if (ev.new_data_cmd) begin
            clr_v = clr_v | CLR_ON_FLOW;                 // [R16] [R17]
        end
        // setting the flow control drops a pending underrun
        if (cfg_wr && pwdata[CFG_FERR_POS]) begin
            clr_v[POS_TX_UNDERRUN] = 1'b1;               // [R17]
        end
    end

    // next-state logic
    always_comb begin
        next_s = s;

        // sticky flags: set is applied last so it wins
        next_s.status = (s.status & ~clr_v) | set_v;
        // level flags track the datapath every cycle
        next_s.status[POS_READ_WAIT]  = ev.read_wait;     // [R1]
        next_s.status[POS_FIFO_EMPTY] = ev.fifo_empty;    // [R13]
        next_s.status[POS_XFER_DONE]  = xfer_idle;        // [R13]

        // capture read data and error in the setup cycle
        if (setup) begin
            next_s.prdata  = rdval;
            next_s.pslverr = !hit;
        end

        // register writes take effect on the access edge
        if (wr) begin
            case (paddr)
                ADDR_IRQ_ENABLE_SET: begin
                    next_s.mask = s.mask | (pwdata & MASK_IMPL);
                end                                          // [R18]
                ADDR_IRQ_ENABLE_CLEAR: begin
                    next_s.mask = s.mask & ~pwdata;          // [R18]
                end
                ADDR_DMA_SETUP: begin
                    if (!s.write_protect_enable) begin       // [R20]
                        next_s.dma.offset   =
                            pwdata[DMA_OFS_LSB +: 2];        // [R21]
                        next_s.dma.chunk    =
                            pwdata[DMA_CHK_LSB +: 3];        // [R22]
                        next_s.dma.enable   = pwdata[DMA_EN_POS];
                        next_s.dma.read_opt = pwdata[DMA_ROPT_POS];
                    end
                end
                ADDR_HOST_CFG: begin
                    // protected like the dma setup
                    if (cfg_wr) begin
                        next_s.cfg.fifo_mode =
                            pwdata[CFG_FIFO_POS];
                        next_s.cfg.flow_error_reset_ctrl =
                            pwdata[CFG_FERR_POS];            // [R23]
                        next_s.cfg.high_speed =
                            pwdata[CFG_HSPD_POS];
                        next_s.cfg.sync_last_block =
                            pwdata[CFG_LSYNC_POS];
                    end
                end
                ADDR_WP_MODE: begin
                    // a wrong key leaves protection as it was
                    if (pwdata[WP_KEY_LSB +: 24] == WP_KEY) begin
                        next_s.write_protect_enable =
                            pwdata[WP_EN_POS];               // [R24]
                    end
                end
                // read-only and unmapped writes are dropped
                default: begin
                    next_s.mask = s.mask;
                end
            endcase
        end

        // registered so irq equals the current flags and mask
        next_s.irq = |(next_s.status & next_s.mask);     // [R25]
    end

    // state register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s.status               <= STATUS_RESET;
            s.mask                 <= MASK_RESET;
            s.dma.offset           <= OFS_RESET;
            s.dma.chunk            <= CHK_RESET;
            s.dma.enable           <= BIT_RESET;
            s.dma.read_opt         <= BIT_RESET;
            s.cfg                  <= '0;
            s.write_protect_enable <= BIT_RESET;
            s.prdata               <= '0;
            s.pslverr              <= BIT_RESET;
            s.irq                  <= BIT_RESET;
        end else begin
            s <= next_s;
        end
    end

    // chunk pacing and first-word byte keep
    cht_chunk_pacer u_pacer (
        .clk        (clk),
        .reset      (reset),
        .chunk      (s.dma.chunk),
        .offset     (s.dma.offset),
        .fifo_count (fifo_count),
        .chunk_req  (chunk_req),
        .first_keep (first_keep)
    );

    // outputs; ready answers in the first access cycle
    assign pready   = access;
    assign pslverr  = access && s.pslverr;
    assign prdata   = s.prdata;
    assign dma_cfg  = s.dma;
    assign host_cfg = s.cfg;
    assign irq      = s.irq;

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    logic ier_wr;     // accepted enable-set write
    logic dma_lock;   // dma write blocked by protection
    logic bad_key;    // protection write with wrong key
    assign ier_wr   = wr && (paddr == ADDR_IRQ_ENABLE_SET);
    assign dma_lock = wr && (paddr == ADDR_DMA_SETUP)
                      && s.write_protect_enable;
    assign bad_key  = wr && (paddr == ADDR_WP_MODE)
                      && (pwdata[WP_KEY_LSB +: 24] != WP_KEY);

    // a status read: setup then access at the same address
    sequence q_status_read;
        (setup && paddr == ADDR_HOST_STATUS) ##1 rd_status;
    endsequence

    property p_read_wait;
        ##1 (s.status[POS_READ_WAIT] == $past(ev.read_wait));
    endproperty
    a_read_wait: assert property (p_read_wait) // [R1]
        else $error("read-wait flag does not follow bus");

    property p_compl_set;
        ev.completion_received |=> s.status[POS_COMPL_RCV];
    endproperty
    a_compl_set: assert property (p_compl_set) // [R2]
        else $error("completion flag not raised");

    property p_index_clear;
        (ev.command_write && !ev.resp_index_err)
            |=> !s.status[POS_RESP_INDEX];
    endproperty
    a_index_clear: assert property (p_index_clear) // [R3]
        else $error("index error survives command write");

    property p_dir_set;
        ev.resp_direction_err |=> s.status[POS_RESP_DIR];
    endproperty
    a_dir_set: assert property (p_dir_set) // [R4]
        else $error("direction error not raised");

    property p_crc_read_clear;
        (q_status_read ##0
            (s.prdata[POS_DATA_CRC] && !ev.data_crc_err))
            |=> !s.status[POS_DATA_CRC];
    endproperty
    a_crc_read_clear: assert property (p_crc_read_clear) // [R8]
        else $error("data crc flag not cleared by read");

    property p_xfer_done;
        ##1 (s.status[POS_XFER_DONE] == $past(xfer_idle));
    endproperty
    a_xfer_done: assert property (p_xfer_done) // [R13]
        else $error("transfer done does not track idle");

    property p_ovr_hold;
        (rd_status && s.status[POS_RX_OVERRUN]
            && !s.cfg.flow_error_reset_ctrl && !ev.new_data_cmd)
            |=> s.status[POS_RX_OVERRUN];
    endproperty
    a_ovr_hold: assert property (p_ovr_hold) // [R23]
        else $error("overrun cleared by read without control");

    property p_ier_sets;
        ier_wr |=> ((s.mask & $past(pwdata) & MASK_IMPL)
            == ($past(pwdata) & MASK_IMPL))
            && ((s.mask & ~$past(pwdata)) == ($past(s.mask)
            & ~$past(pwdata)));
    endproperty
    a_ier_sets: assert property (p_ier_sets) // [R18]
        else $error("enable-set write misbehaves");

    property p_dma_lock;
        dma_lock |=> $stable(s.dma);
    endproperty
    a_dma_lock: assert property (p_dma_lock) // [R20]
        else $error("protected dma setup changed");

    property p_bad_key;
        bad_key |=> $stable(s.write_protect_enable);
    endproperty
    a_bad_key: assert property (p_bad_key) // [R24]
        else $error("protection changed with wrong key");

    // turning on flow control must drop a pending underrun
    property p_tx_underrun_err_cfg_clear;
        (cfg_wr && pwdata[CFG_FERR_POS] && !ev.tx_underrun_err)
            |=> !s.status[POS_TX_UNDERRUN];
    endproperty
    a_tx_underrun_err_cfg_clear: assert property (p_tx_underrun_err_cfg_clear) // [R17]
        else $error("underrun survives flow control set");

    property p_irq;
        irq == |(s.status & s.mask);
    endproperty
    a_irq: assert property (p_irq) // [R25]
        else $error("interrupt disagrees with flags and mask");

    property p_chunk32;
        (s.dma.chunk == CHK_32 && fifo_count < CNT_32
            && $stable(s.dma.chunk)) |=> !chunk_req;
    endproperty
    a_chunk32: assert property (p_chunk32) // [R22]
        else $error("chunk request without enough data");

endmodule

/* rtl/cht_pkg.sv */
// Overview of operation
// R1: read-wait flag follows the bus IO wait state
// R2: completion-received flag sets, status read clears
// R3: response index mismatch flag, command write clears
// R4: response direction bit missing sets a flag
// R5: response CRC7 mismatch flag, command write clears
// R6: response end-bit missing flag, command write clears
// R7: response timeout flag, command write clears
// R8: data CRC16 error flag, status read clears
// R9: data timeout flag, status read clears
// R10: completion timeout flag, status read clears
// R11: dma block overrun flag, status read clears
// R12: dma done flag, status read clears
// R13: fifo-empty level; transfer done when idle
// R14: boot acknowledge flag, status read clears
// R15: corrupted boot acknowledge sets error flag
// R16: overrun flag, new data command clears
// R17: underrun flag, cleared by command or control
// R18: enable/disable registers: ones act, zeros ignored
// R19: mask view returns enabled sources
// R20: dma setup writes ignored when protected
// R21: offset field sets discarded first-word bytes
// R22: chunk request only when chunk data present
// R23: flow-error control picks read clear or not
// R24: protection changes only with the right key
// R25: interrupt high when a flag meets mask
package cht_pkg;

    // register byte addresses
    localparam logic [31:0] ADDR_HOST_STATUS      = 32'hF0008040;
    localparam logic [31:0] ADDR_IRQ_ENABLE_SET   = 32'hF0008044;
    localparam logic [31:0] ADDR_IRQ_ENABLE_CLEAR = 32'hF0008048;
    localparam logic [31:0] ADDR_IRQ_MASK_VIEW    = 32'hF000804C;
    localparam logic [31:0] ADDR_DMA_SETUP        = 32'hF0008050;
    localparam logic [31:0] ADDR_HOST_CFG         = 32'hF0008054;
    localparam logic [31:0] ADDR_WP_MODE          = 32'hF00080E4;

    // status bit positions
    localparam int POS_READ_WAIT   = 12;
    localparam int POS_COMPL_RCV   = 13;
    localparam int POS_RESP_INDEX  = 16;
    localparam int POS_RESP_DIR    = 17;
    localparam int POS_RESP_CRC    = 18;
    localparam int POS_RESP_END    = 19;
    localparam int POS_RESP_TMO    = 20;
    localparam int POS_DATA_CRC    = 21;
    localparam int POS_DATA_TMO    = 22;
    localparam int POS_COMPL_TMO   = 23;
    localparam int POS_BLK_OVR     = 24;
    localparam int POS_DMA_DONE    = 25;
    localparam int POS_FIFO_EMPTY  = 26;
    localparam int POS_XFER_DONE   = 27;
    localparam int POS_BOOT_ACK    = 28;
    localparam int POS_BOOT_ACK_E  = 29;
    localparam int POS_RX_OVERRUN  = 30;
    localparam int POS_TX_UNDERRUN = 31;

    // groups of status bits by clearing event, and the implemented mask bits
    localparam logic [31:0] CLR_ON_READ = 32'h33E02000;
    localparam logic [31:0] CLR_ON_CMD  = 32'h001F0000;
    localparam logic [31:0] CLR_ON_FLOW = 32'hC0000000;
    localparam logic [31:0] MASK_IMPL   = 32'hFFFF313F;

    // dma setup and configuration fields
    localparam int DMA_OFS_LSB    = 0;
    localparam int DMA_CHK_LSB    = 4;
    localparam int DMA_EN_POS     = 8;
    localparam int DMA_ROPT_POS   = 12;
    localparam int CFG_FIFO_POS   = 0;
    localparam int CFG_FERR_POS   = 4;
    localparam int CFG_HSPD_POS   = 8;
    localparam int CFG_LSYNC_POS  = 12;
    localparam int WP_EN_POS      = 0;
    localparam int WP_KEY_LSB     = 8;
    localparam logic [23:0] WP_KEY = 24'h4D4349;

    // reset values
    localparam logic [31:0] STATUS_RESET = 32'h00000000;
    localparam logic [31:0] MASK_RESET   = 32'h00000000;
    localparam logic [1:0]  OFS_RESET    = 2'h0;
    localparam logic [2:0]  CHK_RESET    = 3'h0;
    localparam logic        BIT_RESET    = 1'h0;

    // chunk size codes and the data count each one needs
    localparam logic [2:0] CHK_1  = 3'h0;
    localparam logic [2:0] CHK_4  = 3'h1;
    localparam logic [2:0] CHK_8  = 3'h2;
    localparam logic [2:0] CHK_16 = 3'h3;
    localparam logic [2:0] CHK_32 = 3'h4;
    localparam logic [5:0] CNT_1  = 6'h01;
    localparam logic [5:0] CNT_4  = 6'h04;
    localparam logic [5:0] CNT_8  = 6'h08;
    localparam logic [5:0] CNT_16 = 6'h10;
    localparam logic [5:0] CNT_32 = 6'h20;

    // events and levels from the card datapath
    typedef struct packed {
        logic read_wait;
        logic completion_received;
        logic resp_index_err;
        logic resp_direction_err;
        logic resp_crc_err;
        logic resp_endbit_err;
        logic resp_timeout_err;
        logic data_crc_err;
        logic data_timeout_err;
        logic completion_timeout_err;
        logic dma_block_overrun_err;
        logic dma_done;
        logic fifo_empty;
        logic cmd_ready;
        logic data_idle;
        logic boot_ack;
        logic boot_ack_err;
        logic rx_overrun_err;
        logic tx_underrun_err;
        logic command_write;
        logic new_data_cmd;
    } cht_event_type;

    // dma setup as seen by the datapath
    typedef struct packed {
        logic [1:0] offset;
        logic [2:0] chunk;
        logic       enable;
        logic       read_opt;
    } cht_dma_type;

    // configuration bits as seen by the datapath
    typedef struct packed {
        logic fifo_mode;
        logic flow_error_reset_ctrl;
        logic high_speed;
        logic sync_last_block;
    } cht_cfg_type;

    // whole state of the register bank
    typedef struct packed {
        logic [31:0] status;
        logic [31:0] mask;
        cht_dma_type dma;
        cht_cfg_type cfg;
        logic        write_protect_enable;
        logic [31:0] prdata;
        logic        pslverr;
        logic        irq;
    } cht_state_type;

    // whole state of the chunk pacer
    typedef struct packed {
        logic       req;
        logic [3:0] keep;
    } cht_pacer_type;

endpackage

/* rtl/cht_chunk_pacer.sv */
`timescale 1ns/100ps
module cht_chunk_pacer import cht_pkg::*; (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // dma setup
    input  wire logic [2:0]  chunk,
    input  wire logic [1:0]  offset,
    // fifo fill in data units
    input  wire logic [5:0]  fifo_count,
    // pacing outputs
    output logic             chunk_req,
    output logic [3:0]       first_keep
);

    cht_pacer_type s;      // registered state
    cht_pacer_type next_s; // next state
    logic [5:0]    need;   // data count the chunk needs

    // decode chunk code; unused codes fall back to one
    always_comb begin
        need = CNT_1;
        case (chunk)
            CHK_1:   need = CNT_1;
            CHK_4:   need = CNT_4;
            CHK_8:   need = CNT_8;
            CHK_16:  need = CNT_16;
            CHK_32:  need = CNT_32;
            default: need = CNT_1;
        endcase
        next_s      = s;
        next_s.req  = (fifo_count >= need);     // [R22]
        // low lanes of the first word are dropped
        next_s.keep = 4'(4'hF << offset);       // [R21]
    end

    // state register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign chunk_req  = s.req;
    assign first_keep = s.keep;

endmodule

/* sim/cht_card_model.sv */
`timescale 1ns/100ps
module cht_card_model import cht_pkg::*; (
    // clock
    input  wire logic    clk,
    // datapath events, levels and fifo fill
    output cht_event_type ev,
    output logic [5:0]   fifo_count
);
    // levels held between calls, pulses ride on top
    logic [20:0] lvl;
    initial begin
        lvl = '0;
        ev = '0;
        fifo_count = 6'h00;
    end
    // event lasting exactly one cycle, as the datapath sends it
    task automatic pulse(input int idx);
        @(posedge clk);
        ev <= cht_event_type'(lvl | (21'h1 << idx));
        @(posedge clk);
        ev <= cht_event_type'(lvl);
    endtask
    // bus wait, fifo empty, command ready or data idle level
    task automatic level(input int idx, input logic v);
        @(posedge clk);
        lvl[idx] = v;
        ev <= cht_event_type'(lvl);
    endtask
    // fifo fill as reported to the chunk pacer
    task automatic fill(input logic [5:0] n);
        @(posedge clk);
        fifo_count <= n;
    endtask
endmodule

/* sim/card_host_status_irq_dma_cfg_tb.sv */
`timescale 1ns/100ps
module card_host_status_irq_dma_cfg_tb import cht_pkg::*;;
    // clock, reset and apb master side
    logic          clk;
    logic          reset;
    logic          psel, penable, pwrite, pready, pslverr, err;
    logic [31:0]   paddr, pwdata, prdata, rd;
    logic          irq, chunk_req;
    logic [3:0]    first_keep;
    logic [5:0]    fifo_count;
    cht_event_type ev;
    cht_dma_type   dcfg;
    cht_cfg_type   hcfg;
    int            n_errors, n_compared;
    localparam logic [31:0] S = ADDR_HOST_STATUS;
    always #5 clk = ~clk;
    // block under test, card side comes from the model
    cht_status_regs DUT (.clk(clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ev(ev), .fifo_count(fifo_count),
        .dma_cfg(dcfg), .host_cfg(hcfg), .chunk_req(chunk_req),
        .first_keep(first_keep), .irq(irq));
    cht_card_model card (.clk(clk), .ev(ev), .fifo_count(fifo_count));
    // verdict, reached from the end of the run or a hung wait
    task automatic summarize();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [31:0] a, d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            n_errors++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [31:0] a, exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    task automatic t_reset();
        rdchk(ADDR_IRQ_MASK_VIEW, MASK_RESET, "mask");
        rdchk(ADDR_DMA_SETUP, 32'h00000000, "dma");
        rdchk(S, STATUS_RESET, "status");
        apb(1'b0, 32'hF0008058, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        $display("test reset done");
    endtask
    // sticky flags that a status read clears
    task automatic t_readclr();
        int e[8] = '{19, 13, 12, 11, 10, 9, 5, 4};
        int p[8] = '{13, 21, 22, 23, 24, 25, 28, 29};
        for (int k = 0; k < 8; k++) begin
            card.pulse(e[k]);
            rdchk(S, 32'h1 << p[k], "set");
            rdchk(S, 32'h0, "read clear");
        end
        $display("test read clear done");
    endtask
    // response errors survive reads, a command write clears them
    task automatic t_cmdclr();
        int e[5] = '{18, 17, 16, 15, 14};
        for (int k = 0; k < 5; k++) begin
            card.pulse(e[k]);
            rdchk(S, 32'h1 << (16 + k), "resp");
            rdchk(S, 32'h1 << (16 + k), "kept");
            card.pulse(1);
            rdchk(S, 32'h0, "cmd clear");
        end
        $display("test command clear done");
    endtask
    // level bits; transfer done needs both ready and idle
    task automatic t_levels();
        card.level(20, 1'b1);
        card.level(8, 1'b1);
        card.level(7, 1'b1);
        rdchk(S, 32'h04001000, "levels");
        card.level(6, 1'b1);
        rdchk(S, 32'h0C001000, "idle");
        for (int k = 6; k <= 8; k++)
            card.level(k, 1'b0);
        card.level(20, 1'b0);
        rdchk(S, 32'h0, "levels low");
        $display("test levels done");
    endtask
    task automatic t_flow();
        card.pulse(3);
        rdchk(S, 32'h40000000, "overrun");
        rdchk(S, 32'h40000000, "overrun kept");
        card.pulse(0);
        rdchk(S, 32'h0, "new cmd clear");
        card.pulse(2);
        rdchk(S, 32'h80000000, "underrun");
        apb(1'b1, ADDR_HOST_CFG, 32'h00000010);
        rdchk(S, 32'h0, "ctrl clear");
        chk("cfg out", 32'h4, {28'h0, hcfg});
        card.pulse(3);
        rdchk(S, 32'h40000000, "overrun 2");
        rdchk(S, 32'h0, "flow read clear");
        apb(1'b1, ADDR_HOST_CFG, 32'h0);
        $display("test flow done");
    endtask
    // enable and disable act only on ones; irq follows flag and mask
    task automatic t_mask();
        apb(1'b1, ADDR_IRQ_ENABLE_SET, 32'hFFFFFFFF);
        rdchk(ADDR_IRQ_MASK_VIEW, MASK_IMPL, "mask all");
        apb(1'b1, ADDR_IRQ_ENABLE_CLEAR, 32'hFDFFFFFF);
        apb(1'b1, ADDR_IRQ_ENABLE_SET, 32'h0);
        rdchk(ADDR_IRQ_MASK_VIEW, 32'h02000000, "mask one");
        chk("irq idle", 32'h0, {31'h0, irq});
        card.pulse(9);
        repeat (2) @(posedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b1, ADDR_IRQ_ENABLE_CLEAR, 32'h02000000);
        repeat (2) @(posedge clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        rdchk(S, 32'h02000000, "flag kept");
        $display("test mask done");
    endtask
    task automatic t_dma();
        logic [5:0] n[5] = '{CNT_1, CNT_4, CNT_8, CNT_16, CNT_32};
        for (int k = 0; k < 5; k++) begin
            apb(1'b1, ADDR_DMA_SETUP, {25'h0, 3'(k), 2'h0, 2'(k)});
            card.fill(n[k] - 6'h01);
            repeat (2) @(posedge clk);
            chk("short", 32'h0, {31'h0, chunk_req});
            card.fill(n[k]);
            repeat (2) @(posedge clk);
            chk("chunk", 32'h1, {31'h0, chunk_req});
            chk("keep", {28'h0, 4'hF << 2'(k)}, {28'h0, first_keep});
        end
        apb(1'b1, ADDR_WP_MODE, 32'h12345601);
        apb(1'b1, ADDR_DMA_SETUP, 32'h00000003);
        rdchk(ADDR_DMA_SETUP, 32'h00000003, "bad key");
        apb(1'b1, ADDR_WP_MODE, {WP_KEY, 8'h01});
        apb(1'b1, ADDR_DMA_SETUP, 32'h00000001);
        rdchk(ADDR_DMA_SETUP, 32'h00000003, "protected");
        chk("dma out", 32'h60, {25'h0, dcfg});
        apb(1'b1, ADDR_WP_MODE, {WP_KEY, 8'h00});
        $display("test dma done");
    endtask
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        n_errors = 0;
        n_compared = 0;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_readclr();
        t_cmdclr();
        t_levels();
        t_flow();
        t_mask();
        t_dma();
        summarize();
    end
endmodule
